// ==== scdd_map.svh ====
/*
 * Constants of the sample clock delay and detect register block: register
 * indices, field positions, reset values, mode codes and timing counts.
 * Assumes it is included by bare name from packages and modules alike.
 */
`ifndef SCDD_MAP_SVH
`define SCDD_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define SCDD_IDX_SUPERFINE      10'h111
`define SCDD_IDX_FINE           10'h112
`define SCDD_IDX_STATUS         10'h11B
`define SCDD_IDX_STAB_CTRL      10'h11C
`define SCDD_ADDR_W             12

// ****************************************************************
// Field positions and reset values
// ****************************************************************
`define SCDD_BIT_CLK_DETECT     0
`define SCDD_BIT_STAB_EN        1
`define SCDD_RST_SUPERFINE      8'h00
`define SCDD_RST_FINE           8'hC0
`define SCDD_RST_STATUS         8'h00
`define SCDD_RST_STAB_CTRL      8'h02

// ****************************************************************
// Delay mode codes and code limits
// ****************************************************************
`define SCDD_MODE_FINE_NARROW   3'h2
`define SCDD_MODE_FINE_LOWJIT   3'h3
`define SCDD_MODE_FINE_WIDE     3'h4
`define SCDD_MODE_FINE_SUPER    3'h6
`define SCDD_FINE_MAX           8'hC0
`define SCDD_FINE_NARROW_MAX    8'h10

// ****************************************************************
// Step sizes and timing
// ****************************************************************
`define SCDD_SUPERFINE_STEP_FS  250
`define SCDD_FINE_STEP_FS       1725
`define SCDD_CLK_MHZ            50
`define SCDD_DETECT_QUAL_NS     1000
`define SCDD_DETECT_QUAL_CYC    ((`SCDD_DETECT_QUAL_NS * `SCDD_CLK_MHZ) / 1000)

`endif

// ==== scdd_pkg.sv ====
/*
 * Types of the sample clock delay and detect register block.
 * Assumes scdd_map.svh is on the include path.
 */
package scdd_pkg;

    // ****************************************************************
    // Clock detect qualifier states, Gray coded along lost-qual-locked
    // ****************************************************************
    typedef enum logic [1:0] {
        SCDD_DET_LOST   = 2'b00,
        SCDD_DET_QUAL   = 2'b01,
        SCDD_DET_LOCKED = 2'b11
    } scdd_det_state_t;

    // ****************************************************************
    // State of the register block
    // ****************************************************************
    typedef struct packed {
        logic [7:0]      superfine;
        logic [7:0]      fine;
        logic            stab_en;
        scdd_det_state_t det;
        logic [15:0]     det_cnt;
        logic [31:0]     prdata;
        logic            pslverr;
    } scdd_regs_t;

    // ****************************************************************
    // State of the delay apply stage
    // ****************************************************************
    typedef struct packed {
        logic [7:0] superfine_eff;
        logic [7:0] fine_eff;
        logic       superfine_on;
        logic       fine_on;
    } scdd_apply_t;

endpackage

// ==== scdd_dly_if.sv ====
/*
 * Carrier between the register block and the delay apply stage.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps

interface scdd_dly_if;
    logic [2:0] mode;
    logic [7:0] superfine_code;
    logic [7:0] fine_code;
    logic [7:0] superfine_eff;
    logic [7:0] fine_eff;
    logic       superfine_on;
    logic       fine_on;

    modport ctrl (output mode, output superfine_code, output fine_code,
                  input superfine_eff, input fine_eff, input superfine_on, input fine_on);
    modport apply (input mode, input superfine_code, input fine_code,
                   output superfine_eff, output fine_eff, output superfine_on, output fine_on);
endinterface

// ==== scdd_delay_apply.sv ====
/*
 * Delay apply stage: decides from the delay mode which codes reach the
 * analog delay line and limits the fine code to the range that mode allows.
 * Assumes mode and codes are synchronous to pclk.
 */
`timescale 1ns/1ps
`include "scdd_map.svh"

module scdd_delay_apply #(
    parameter logic [7:0] FINE_MAX        = `SCDD_FINE_MAX,
    parameter logic [7:0] FINE_NARROW_MAX = `SCDD_FINE_NARROW_MAX
) (
    // Clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // Codes in, applied codes out
    scdd_dly_if.apply        dly
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (FINE_NARROW_MAX > FINE_MAX) begin : g_bad_limits
        $error("Narrow fine limit exceeds full fine limit.");
    end

    // ****************************************************************
    // Mode decoding
    // ****************************************************************
    function automatic logic superfine_mode(input logic [2:0] m);
        return (m == `SCDD_MODE_FINE_NARROW) || (m == `SCDD_MODE_FINE_SUPER);
    endfunction

    function automatic logic narrow_mode(input logic [2:0] m);
        return (m == `SCDD_MODE_FINE_NARROW) || (m == `SCDD_MODE_FINE_LOWJIT);
    endfunction

    function automatic logic fine_mode(input logic [2:0] m);
        return narrow_mode(m) || (m == `SCDD_MODE_FINE_WIDE) || (m == `SCDD_MODE_FINE_SUPER);
    endfunction

    scdd_pkg::scdd_apply_t state;
    scdd_pkg::scdd_apply_t next_state;

    // Codes outside the active modes are forced to zero so the delay line
    // never sees a stale step count when the mode changes.
    always_comb begin
        logic [7:0] limit;
        limit = FINE_MAX;
        next_state = state;
        if (narrow_mode(dly.mode)) begin
            limit = FINE_NARROW_MAX;
        end
        next_state.superfine_on  = superfine_mode(dly.mode);
        next_state.superfine_eff = superfine_mode(dly.mode) ? dly.superfine_code : 8'h00;
        next_state.fine_on       = fine_mode(dly.mode);
        if (!fine_mode(dly.mode)) begin
            next_state.fine_eff = 8'h00;
        end else if (dly.fine_code > limit) begin
            next_state.fine_eff = limit;
        end else begin
            next_state.fine_eff = dly.fine_code;
        end
    end

    // State register.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign dly.superfine_eff = state.superfine_eff;
    assign dly.fine_eff      = state.fine_eff;
    assign dly.superfine_on  = state.superfine_on;
    assign dly.fine_on       = state.fine_on;

endmodule

// ==== scdd_clock_regs.sv ====
/*
 * Sample clock delay and detect register block with an APB slave.
 * Holds the superfine and fine delay codes, the clock detect status and
 * the first duty cycle stabilizer control, and drives the delay line codes.
 * Assumes the delay mode field and the raw clock present level come from
 * neighbouring logic synchronous to pclk.
 */
// Register access over APB was chosen for this implementation.
// Overview of operation
// - Superfine code is 8 bits unsigned, 0.25 ps per step, code equals steps.
// - Superfine code is applied only in delay modes 010 and 110.
// - Fine code is 8 bits unsigned, 1.725 ps of skew per step.
// - Fine code is applied only in delay modes 2, 3, 4 and 6.
// - Fine code resets to 0xC0, the maximum of 192 steps.
// - Status bit 0 reads 1 when the input clock is detected, resets 0.
// - Modes 010 and 011 allow fine codes 0 to 16; modes 100, 110 all 192.
`timescale 1ns/1ps
`include "scdd_map.svh"

module scdd_clock_regs #(
    parameter int unsigned DETECT_QUAL_CYC = `SCDD_DETECT_QUAL_CYC
) (
    // Clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // APB slave
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [`SCDD_ADDR_W-1:0] paddr,
    input  wire logic [31:0]             pwdata,
    input  wire logic [3:0]              pstrb,
    output wire logic [31:0]             prdata,
    output wire logic                    pready,
    output wire logic                    pslverr,
    // Neighbouring control and analog status
    input  wire logic [2:0]              delay_mode_sel,
    input  wire logic                    input_clock_present,
    // Clock path controls
    output wire logic [7:0]              superfine_delay_code,
    output wire logic [7:0]              fine_delay_code,
    output wire logic                    superfine_delay_active,
    output wire logic                    fine_delay_active,
    output wire logic                    stabilizer_first_enable,
    output wire logic                    input_clock_detected
);

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    if (DETECT_QUAL_CYC < 1 || DETECT_QUAL_CYC > 65535) begin : g_bad_qual
        $error("Clock detect qualification count must be 1 to 65535.");
    end

    localparam logic [15:0] QUAL_LAST = 16'(DETECT_QUAL_CYC - 1);

    localparam logic [`SCDD_ADDR_W-1:0] ADDR_SUPERFINE = {`SCDD_IDX_SUPERFINE, 2'b00};
    localparam logic [`SCDD_ADDR_W-1:0] ADDR_FINE      = {`SCDD_IDX_FINE, 2'b00};
    localparam logic [`SCDD_ADDR_W-1:0] ADDR_STATUS    = {`SCDD_IDX_STATUS, 2'b00};
    localparam logic [`SCDD_ADDR_W-1:0] ADDR_STAB_CTRL = {`SCDD_IDX_STAB_CTRL, 2'b00};

    // ****************************************************************
    // Address decoding
    // ****************************************************************
    function automatic logic addr_mapped(input logic [`SCDD_ADDR_W-1:0] a);
        return (a == ADDR_SUPERFINE) || (a == ADDR_FINE) || (a == ADDR_STATUS) || (a == ADDR_STAB_CTRL);
    endfunction

    scdd_pkg::scdd_regs_t state;
    scdd_pkg::scdd_regs_t next_state;
    scdd_dly_if           dly ();

    logic setup_phase;
    logic access_phase;
    logic wr_lane0;
    logic clk_detected;

    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_lane0     = access_phase && pwrite && pstrb[0] && addr_mapped(paddr);
    assign clk_detected = (state.det == scdd_pkg::SCDD_DET_LOCKED);

    // ****************************************************************
    // Next state
    // ****************************************************************
    // Read data and the error answer are captured in the setup cycle, so the
    // access cycle can answer at once from flip-flops with no wait state.
    always_comb begin
        next_state = state;

        // Clock detect qualifier: the raw level must stay high for the whole
        // qualification time, which filters glitches while the clock starts.
        unique case (state.det)
            scdd_pkg::SCDD_DET_LOST: begin
                next_state.det_cnt = 16'h0000;
                if (input_clock_present) begin
                    next_state.det = scdd_pkg::SCDD_DET_QUAL;
                end
            end
            scdd_pkg::SCDD_DET_QUAL: begin
                if (!input_clock_present) begin
                    next_state.det = scdd_pkg::SCDD_DET_LOST;
                end else if (state.det_cnt >= QUAL_LAST) begin
                    next_state.det = scdd_pkg::SCDD_DET_LOCKED;
                end else begin
                    next_state.det_cnt = state.det_cnt + 16'h0001;
                end
            end
            scdd_pkg::SCDD_DET_LOCKED: begin
                if (!input_clock_present) begin
                    next_state.det = scdd_pkg::SCDD_DET_LOST;
                end
            end
            default: begin
                next_state.det = scdd_pkg::SCDD_DET_LOST;
            end
        endcase

        // Register writes take effect in the access cycle only.
        if (wr_lane0) begin
            unique case (paddr)
                ADDR_SUPERFINE: next_state.superfine = pwdata[7:0];
                ADDR_FINE:      next_state.fine = pwdata[7:0];
                ADDR_STAB_CTRL: next_state.stab_en = pwdata[`SCDD_BIT_STAB_EN];
                default:        next_state.fine = state.fine;
            endcase
        end

        // Read data capture; reserved bits read as zero.
        if (setup_phase) begin
            next_state.prdata  = 32'h0000_0000;
            next_state.pslverr = !addr_mapped(paddr);
            if (!pwrite) begin
                unique case (paddr)
                    ADDR_SUPERFINE: next_state.prdata[7:0] = state.superfine;
                    ADDR_FINE:      next_state.prdata[7:0] = state.fine;
                    ADDR_STATUS:    next_state.prdata[`SCDD_BIT_CLK_DETECT] = clk_detected;
                    ADDR_STAB_CTRL: next_state.prdata[`SCDD_BIT_STAB_EN] = state.stab_en;
                    default:        next_state.prdata = 32'h0000_0000;
                endcase
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state           <= '0;
            state.superfine <= `SCDD_RST_SUPERFINE;
            state.fine      <= `SCDD_RST_FINE;
            state.stab_en   <= 1'(`SCDD_RST_STAB_CTRL >> `SCDD_BIT_STAB_EN);
            state.det       <= scdd_pkg::SCDD_DET_LOST;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Delay apply stage
    // ****************************************************************
    // Codes above the range software should use are limited in the apply
    // stage rather than refused, so a readback still shows what was written.
    assign dly.mode           = delay_mode_sel;
    assign dly.superfine_code = state.superfine;
    assign dly.fine_code      = state.fine;

    scdd_delay_apply #(
        .FINE_MAX        (`SCDD_FINE_MAX),
        .FINE_NARROW_MAX (`SCDD_FINE_NARROW_MAX)
    ) scdd_delay_apply_inst (
        .pclk    (pclk),
        .presetn (presetn),
        .dly     (dly.apply)
    );

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata                  = state.prdata;
    assign pslverr                 = state.pslverr && access_phase;
    assign pready                  = 1'b1;
    assign superfine_delay_code    = dly.superfine_eff;
    assign fine_delay_code         = dly.fine_eff;
    assign superfine_delay_active  = dly.superfine_on;
    assign fine_delay_active       = dly.fine_on;
    assign stabilizer_first_enable = state.stab_en;
    assign input_clock_detected    = clk_detected;

endmodule

// ==== scdd_clock_regs_props.sv ====
/*
 * Checker of the sample clock delay and detect register block.
 * Assumes one clock, pclk, and the asynchronous active-low reset presetn.
 */
`timescale 1ns/1ps
`include "scdd_map.svh"

module scdd_clock_regs_props #(
    parameter int unsigned DETECT_QUAL_CYC = `SCDD_DETECT_QUAL_CYC
) (
    // Clock and reset
    input wire logic                    pclk,
    input wire logic                    presetn,
    // APB slave
    input wire logic                    psel,
    input wire logic                    penable,
    input wire logic                    pwrite,
    input wire logic [`SCDD_ADDR_W-1:0] paddr,
    input wire logic [31:0]             pwdata,
    input wire logic [3:0]              pstrb,
    input wire logic [31:0]             prdata,
    input wire logic                    pready,
    input wire logic                    pslverr,
    // Mode and clock present
    input wire logic [2:0]              delay_mode_sel,
    input wire logic                    input_clock_present,
    // Clock path controls
    input wire logic [7:0]              superfine_delay_code,
    input wire logic [7:0]              fine_delay_code,
    input wire logic                    superfine_delay_active,
    input wire logic                    fine_delay_active,
    input wire logic                    stabilizer_first_enable,
    input wire logic                    input_clock_detected
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    localparam logic [11:0] SF = {`SCDD_IDX_SUPERFINE, 2'b00};
    localparam logic [11:0] FN = {`SCDD_IDX_FINE, 2'b00};
    localparam logic [11:0] ST = {`SCDD_IDX_STATUS, 2'b00};
    localparam logic [11:0] CT = {`SCDD_IDX_STAB_CTRL, 2'b00};
    logic [15:0] hi_cnt;
    logic        wr;

    // A write lands only when the low byte strobe is set.
    assign wr = psel && penable && pwrite && pstrb[0];

    // Run of edges with the clock present; saturates so a long run cannot wrap.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hi_cnt <= 16'h0000;
        end else if (!input_clock_present) begin
            hi_cnt <= 16'h0000;
        end else if (hi_cnt != 16'hFFFF) begin
            hi_cnt <= hi_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_sf_active;
        1'b1 |=> superfine_delay_active == ($past(delay_mode_sel) inside {3'h2, 3'h6});
    endproperty
    a_sf_active: assert property (p_sf_active) else $error("superfine active flag wrong for mode");
    property p_sf_zero;
        !superfine_delay_active |-> superfine_delay_code == 8'h00;
    endproperty
    a_sf_zero: assert property (p_sf_zero) else $error("superfine code driven while inactive");
    property p_fn_active;
        1'b1 |=> fine_delay_active == ($past(delay_mode_sel) inside {3'h2, 3'h3, 3'h4, 3'h6});
    endproperty
    a_fn_active: assert property (p_fn_active) else $error("fine active flag wrong for mode");
    property p_fn_zero;
        !fine_delay_active |-> fine_delay_code == 8'h00;
    endproperty
    a_fn_zero: assert property (p_fn_zero) else $error("fine code driven while inactive");
    property p_fn_narrow;
        delay_mode_sel inside {3'h2, 3'h3} |=> fine_delay_code <= 8'h10;
    endproperty
    a_fn_narrow: assert property (p_fn_narrow) else $error("fine code above narrow limit");
    property p_sf_write;
        wr && paddr == SF && delay_mode_sel == 3'h6 ##1 delay_mode_sel == 3'h6
            |=> {24'h0, superfine_delay_code} == ($past(pwdata, 2) & 32'hFF);
    endproperty
    a_sf_write: assert property (p_sf_write) else $error("superfine code not applied");
    property p_fn_write;
        wr && paddr == FN && delay_mode_sel == 3'h4 && pwdata[7:0] <= 8'hC0 ##1 delay_mode_sel == 3'h4
            |=> {24'h0, fine_delay_code} == ($past(pwdata, 2) & 32'hFF);
    endproperty
    a_fn_write: assert property (p_fn_write) else $error("fine code not applied");
    property p_detect;
        input_clock_detected == (hi_cnt > DETECT_QUAL_CYC);
    endproperty
    a_detect: assert property (p_detect) else $error("clock detect out of step with input");
    property p_rd_status;
        psel && !penable && !pwrite && paddr == ST |=> prdata == {31'h0, $past(input_clock_detected)};
    endproperty
    a_rd_status: assert property (p_rd_status) else $error("status read differs from detect");
    property p_stab;
        wr && paddr == CT |=> stabilizer_first_enable == |($past(pwdata) & 32'h2);
    endproperty
    a_stab: assert property (p_stab) else $error("stabilizer enable not written");
endmodule

bind scdd_clock_regs scdd_clock_regs_props #(.DETECT_QUAL_CYC(DETECT_QUAL_CYC)) scdd_clock_regs_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .delay_mode_sel(delay_mode_sel), .input_clock_present(input_clock_present),
    .superfine_delay_code(superfine_delay_code), .fine_delay_code(fine_delay_code),
    .superfine_delay_active(superfine_delay_active), .fine_delay_active(fine_delay_active),
    .stabilizer_first_enable(stabilizer_first_enable), .input_clock_detected(input_clock_detected));

// ==== scdd_clock_regs_tb.sv ====
/*
 * Self-checking testbench of the sample clock delay and detect register block.
 * Assumes the checker is bound and the detect qualifier count is shortened.
 */
`timescale 1ns/1ps
`include "scdd_map.svh"

module scdd_clock_regs_tb;
    localparam int unsigned QUAL = 2;
    localparam logic [11:0] A_SF = {`SCDD_IDX_SUPERFINE, 2'b00};
    localparam logic [11:0] A_FN = {`SCDD_IDX_FINE, 2'b00};
    localparam logic [11:0] A_ST = {`SCDD_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_CT = {`SCDD_IDX_STAB_CTRL, 2'b00};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic [3:0]  pstrb;
    logic [2:0]  delay_mode_sel;
    logic        input_clock_present, sf_act, fn_act, stab_en, clk_det, sf_on, fn_on;
    logic [7:0]  sf_code, fn_code, fn_exp;
    int          errors, num_checks;

    scdd_clock_regs #(.DETECT_QUAL_CYC(QUAL)) scdd_clock_regs_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .delay_mode_sel(delay_mode_sel), .input_clock_present(input_clock_present),
        .superfine_delay_code(sf_code), .fine_delay_code(fn_code), .superfine_delay_active(sf_act),
        .fine_delay_active(fn_act), .stabilizer_first_enable(stab_en), .input_clock_detected(clk_det));

    // Clock of 20 ns.
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // One APB transfer; the wait for pready is bounded so a stuck slave ends the run.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            $display("wrong value pready expected 1 seen %b", pready);
            finish_test();
        end else begin
            rdata = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0);
        chk(nm, exp, rdata);
        chk("slave error", {31'h0, err}, {31'h0, rerr});
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        delay_mode_sel = 3'h0;
        input_clock_present = 1'b0;
        errors = 0;
        num_checks = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd("superfine", A_SF, 32'h00, 1'b0);
        rd("fine", A_FN, 32'hC0, 1'b0);
        rd("status", A_ST, 32'h00, 1'b0);
        rd("stabilizer ctrl", A_CT, 32'h02, 1'b0);
        chk("stabilizer out", 32'h1, {31'h0, stab_en});
        $display("test reset values done");
        // Modes stay put one edge past each write so the applied code can be seen.
        delay_mode_sel <= 3'h6;
        apb(1'b1, A_SF, 32'h80);
        @(posedge pclk);
        delay_mode_sel <= 3'h4;
        apb(1'b1, A_FN, 32'hA5);
        pstrb <= 4'hE;
        apb(1'b1, A_FN, 32'h33);
        pstrb <= 4'hF;
        rd("superfine", A_SF, 32'h80, 1'b0);
        rd("fine", A_FN, 32'hA5, 1'b0);
        apb(1'b1, A_CT, 32'h00);
        rd("stabilizer ctrl", A_CT, 32'h00, 1'b0);
        chk("stabilizer out", 32'h0, {31'h0, stab_en});
        apb(1'b1, A_CT, 32'h03);
        rd("stabilizer ctrl", A_CT, 32'h02, 1'b0);
        chk("stabilizer out", 32'h1, {31'h0, stab_en});
        $display("test register writes done");
        // Every mode: fine 0xA5 is clamped to 16 in the narrow modes.
        for (int m = 0; m < 8; m++) begin
            delay_mode_sel <= m[2:0];
            repeat (2) @(posedge pclk);
            sf_on = (m == 2 || m == 6);
            fn_on = (m == 2 || m == 3 || m == 4 || m == 6);
            fn_exp = !fn_on ? 8'h00 : (m < 4 ? 8'h10 : 8'hA5);
            chk("superfine active", {31'h0, sf_on}, {31'h0, sf_act});
            chk("superfine code", sf_on ? 32'h80 : 32'h0, {24'h0, sf_code});
            chk("fine active", {31'h0, fn_on}, {31'h0, fn_act});
            chk("fine code", {24'h0, fn_exp}, {24'h0, fn_code});
        end
        $display("test delay modes done");
        rd("unmapped", 12'h474, 32'h0, 1'b1);
        apb(1'b1, 12'h440, 32'h55);
        chk("unmapped write error", 32'h1, {31'h0, rerr});
        apb(1'b1, A_ST, 32'hFF);
        rd("status", A_ST, 32'h00, 1'b0);
        $display("test refused accesses done");
        input_clock_present <= 1'b1;
        repeat (QUAL) @(posedge pclk);
        chk("detect early", 32'h0, {31'h0, clk_det});
        repeat (2) @(posedge pclk);
        chk("detect out", 32'h1, {31'h0, clk_det});
        rd("status", A_ST, 32'h01, 1'b0);
        input_clock_present <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("detect out", 32'h0, {31'h0, clk_det});
        rd("status", A_ST, 32'h00, 1'b0);
        $display("test clock detect done");
        finish_test();
    end
endmodule
